/* hdl/pbcu_pkg.sv */
// Constants for the bridge control upper half block
package pbcu_pkg;
    localparam logic [7:0]  BRIDGE_CONTROL_UPPER_OFF = 8'h3C;
    localparam logic [31:0] BRIDGE_CONTROL_UPPER_RST = 32'h0000_0000;
    // Field positions within the configuration dword
    localparam int VGA_DECODE_BIT     = 19;
    localparam int RSVD_LOW_BIT       = 20;
    localparam int MA_MODE_BIT        = 21;
    localparam int SEC_RESET_BIT      = 22;
    localparam int FAST_B2B_BIT       = 23;
    localparam int PRI_SHORT_TMO_BIT  = 24;
    localparam int SEC_SHORT_TMO_BIT  = 25;
    localparam int TMO_STATUS_BIT     = 26;
    localparam int TMO_SERR_EN_BIT    = 27;
    localparam int RSVD_HIGH_MSB      = 31;
    localparam int RSVD_HIGH_LSB      = 28;
    localparam int BE_LANE2           = 2;
    localparam int BE_LANE3           = 3;
    // VGA memory frame buffer range
    localparam logic [31:0] VGA_MEM_LO  = 32'h000A_0000;
    localparam logic [31:0] VGA_MEM_HI  = 32'h000B_FFFF;
    // VGA I/O ranges on the low ten address bits
    localparam logic [9:0]  VGA_IO_A_LO = 10'h3B0;
    localparam logic [9:0]  VGA_IO_A_HI = 10'h3BB;
    localparam logic [9:0]  VGA_IO_B_LO = 10'h3C0;
    localparam logic [9:0]  VGA_IO_B_HI = 10'h3DF;
    localparam logic [15:0] IO_UPPER_ZERO = 16'h0000;
    // ISA aliasing: the low 256 bytes of each 1KB block stay forwarded
    localparam logic [9:0]  ISA_KEEP_MAX  = 10'h0FF;
    localparam logic [31:0] IO_FIRST_64K  = 32'h0000_FFFF;
    // Discard limits in PCI clocks
    localparam int DISCARD_LONG_CLKS  = 32768;
    localparam int DISCARD_SHORT_CLKS = 1024;
    localparam int DISCARD_CNT_W      = 16;
    localparam logic [31:0] MA_READ_ONES = 32'hFFFF_FFFF;
    localparam int NUM_BUSES          = 2;
    localparam int PRI_BUS            = 0;
    localparam int SEC_BUS            = 1;

    typedef enum logic {
        PBCU_TMR_IDLE,
        PBCU_TMR_RUN
    } pbcu_tmr_e;
endpackage

/* hdl/pbcu_bridge_ctrl.sv */
// Bridge control upper half: VGA decode, master abort, reset, timers
module pbcu_bridge_ctrl
    import pbcu_pkg::*;
#(
    parameter int LONG_LIMIT  = DISCARD_LONG_CLKS,
    parameter int SHORT_LIMIT = DISCARD_SHORT_CLKS
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    // Configuration access
    input  wire logic                 cfg_wr,
    input  wire logic                 cfg_rd,
    input  wire logic [7:0]           cfg_addr,
    input  wire logic [3:0]           cfg_be,
    input  wire logic [31:0]          cfg_wdata,
    output logic      [31:0]          cfg_rdata,
    output logic                      cfg_rvalid,
    // Command register and window context
    input  wire logic                 cmd_io_en,
    input  wire logic                 cmd_mem_en,
    input  wire logic                 cmd_serr_en,
    input  wire logic                 isa_mode,
    input  wire logic [31:0]          io_base,
    input  wire logic [31:0]          io_limit,
    // Primary decode
    input  wire logic                 pri_valid,
    input  wire logic                 pri_is_mem,
    input  wire logic                 pri_is_io,
    input  wire logic [31:0]          pri_addr,
    output logic                      pri_claim,
    // Secondary decode
    input  wire logic                 sec_valid,
    input  wire logic                 sec_is_mem,
    input  wire logic                 sec_is_io,
    input  wire logic [31:0]          sec_addr,
    output logic                      sec_vga_ignore,
    // Master abort reports
    input  wire logic                 ma_event,
    input  wire logic                 ma_delayed,
    input  wire logic                 ma_read,
    output logic                      ma_trdy_done,
    output logic                      ma_target_abort,
    output logic      [31:0]          ma_read_data,
    // Secondary reset and fast back-to-back
    output logic                      sec_rst_out_b,
    output logic                      sec_logic_reset,
    output logic                      sec_fast_b2b_en,
    // Discard timers, index 0 primary, 1 secondary
    input  wire logic [NUM_BUSES-1:0] dt_head_arrive,
    input  wire logic [NUM_BUSES-1:0] dt_repeat,
    output logic      [NUM_BUSES-1:0] dt_discard,
    output logic                      primary_system_error_out
);

    localparam logic [DISCARD_CNT_W-1:0] LONG_LAST =
        DISCARD_CNT_W'(LONG_LIMIT - 1);
    localparam logic [DISCARD_CNT_W-1:0] SHORT_LAST =
        DISCARD_CNT_W'(SHORT_LIMIT - 1);

    logic                      vga_en_q;
    logic                      ma_mode_q;
    logic                      sec_reset_q;
    logic                      pri_short_q;
    logic                      sec_short_q;
    logic                      tmo_status_q;
    logic                      tmo_serr_en_q;
    logic                      reg_hit;
    logic                      wr_lane2;
    logic                      wr_lane3;
    logic [31:0]               reg_view;
    logic [NUM_BUSES-1:0]      short_sel;
    logic [NUM_BUSES-1:0]      discard_now;
    logic                      pri_vga;
    logic                      pri_window;
    logic                      pri_isa_alias;
    logic                      vga_active;

    // VGA memory range test, used for both buses
    function automatic logic vga_mem_hit(input logic [31:0] a);
        vga_mem_hit = (a >= VGA_MEM_LO) && (a <= VGA_MEM_HI);
    endfunction

    // VGA I/O test: bits 15:10 are not decoded
    function automatic logic vga_io_hit(input logic [31:0] a);
        logic [9:0] lo;
        lo = a[9:0];
        vga_io_hit = (a[31:16] == IO_UPPER_ZERO) &&
                     (((lo >= VGA_IO_A_LO) && (lo <= VGA_IO_A_HI)) ||
                      ((lo >= VGA_IO_B_LO) && (lo <= VGA_IO_B_HI)));
    endfunction

    // Cycle-type gated VGA hit, shared by both buses
    function automatic logic vga_hit(input logic m, input logic i,
                                     input logic [31:0] a);
        vga_hit = (m && vga_mem_hit(a)) || (i && vga_io_hit(a));
    endfunction

    assign reg_hit  = (cfg_addr == BRIDGE_CONTROL_UPPER_OFF);
    assign wr_lane2 = cfg_wr && reg_hit && cfg_be[BE_LANE2];
    assign wr_lane3 = cfg_wr && reg_hit && cfg_be[BE_LANE3];

    // Register write path; secondary reset never touches these flops
    // config kept
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            vga_en_q      <= BRIDGE_CONTROL_UPPER_RST[VGA_DECODE_BIT];
            ma_mode_q     <= BRIDGE_CONTROL_UPPER_RST[MA_MODE_BIT];
            sec_reset_q   <= BRIDGE_CONTROL_UPPER_RST[SEC_RESET_BIT];
            pri_short_q   <= BRIDGE_CONTROL_UPPER_RST[PRI_SHORT_TMO_BIT];
            sec_short_q   <= BRIDGE_CONTROL_UPPER_RST[SEC_SHORT_TMO_BIT];
            tmo_serr_en_q <= BRIDGE_CONTROL_UPPER_RST[TMO_SERR_EN_BIT];
        end else begin
            if (wr_lane2) begin
                vga_en_q    <= cfg_wdata[VGA_DECODE_BIT];
                ma_mode_q   <= cfg_wdata[MA_MODE_BIT];
                sec_reset_q <= cfg_wdata[SEC_RESET_BIT];
            end
            if (wr_lane3) begin
                pri_short_q   <= cfg_wdata[PRI_SHORT_TMO_BIT];
                sec_short_q   <= cfg_wdata[SEC_SHORT_TMO_BIT];
                tmo_serr_en_q <= cfg_wdata[TMO_SERR_EN_BIT];
            end
        end
    end

    // sticky timeout
    // A discard in the same cycle as the clear keeps the flag set
    // Only a lane 3 write can carry the clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tmo_status_q <= BRIDGE_CONTROL_UPPER_RST[TMO_STATUS_BIT];
        end else if (|discard_now) begin
            tmo_status_q <= 1'b1;
        end else if (wr_lane3 && cfg_wdata[TMO_STATUS_BIT]) begin
            tmo_status_q <= 1'b0;
        end
    end

    always_comb begin
        reg_view                    = 32'h0000_0000;
        reg_view[VGA_DECODE_BIT]    = vga_en_q;
        reg_view[RSVD_LOW_BIT]      = 1'b0;
        reg_view[MA_MODE_BIT]       = ma_mode_q;
        reg_view[SEC_RESET_BIT]     = sec_reset_q;
        reg_view[FAST_B2B_BIT]      = 1'b0;
        reg_view[PRI_SHORT_TMO_BIT] = pri_short_q;
        reg_view[SEC_SHORT_TMO_BIT] = sec_short_q;
        reg_view[TMO_STATUS_BIT]    = tmo_status_q;
        reg_view[TMO_SERR_EN_BIT]   = tmo_serr_en_q;
        reg_view[RSVD_HIGH_MSB:RSVD_HIGH_LSB] = 4'h0;
    end

    // Read answer one cycle later; other offsets read zero
    // Data holds after the strobe until the next read
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_rdata  <= 32'h0000_0000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
            if (cfg_rd) begin
                cfg_rdata <= reg_hit ? reg_view : 32'h0000_0000;
            end
        end
    end

    assign vga_active = vga_en_q && cmd_io_en && cmd_mem_en;

    assign pri_vga = vga_active && vga_hit(pri_is_mem, pri_is_io, pri_addr);

    // Inclusive window bounds; the I/O space enable gates it
    assign pri_window = pri_is_io && (pri_addr >= io_base) &&
                        (pri_addr <= io_limit) && cmd_io_en;

    assign pri_isa_alias = isa_mode && (pri_addr <= IO_FIRST_64K) &&
                           (pri_addr[9:0] > ISA_KEEP_MAX);

    // VGA off path
    // Window claims still apply when VGA is off; ISA aliases are dropped
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pri_claim <= 1'b0;
        end else begin
            pri_claim <= pri_valid &&
                         (pri_vga || (pri_window && !pri_isa_alias));
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sec_vga_ignore <= 1'b0;
        end else begin
            sec_vga_ignore <= sec_valid && vga_active &&
                              vga_hit(sec_is_mem, sec_is_io, sec_addr);
        end
    end

    // Read data holds, so a late fetch still returns all ones
    // mode 0 completion and mode 1 target abort
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ma_trdy_done    <= 1'b0;
            ma_target_abort <= 1'b0;
            ma_read_data    <= 32'h0000_0000;
        end else begin
            ma_trdy_done    <= ma_event && ma_delayed && !ma_mode_q;
            ma_target_abort <= ma_event && ma_delayed && ma_mode_q;
            if (ma_event && ma_delayed && !ma_mode_q && ma_read) begin
                ma_read_data <= MA_READ_ONES;
            end
        end
    end

    // secondary reset
    // Level follows the bit with one flop of delay only
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sec_rst_out_b   <= 1'b1;
            sec_logic_reset <= 1'b0;
        end else begin
            sec_rst_out_b   <= !sec_reset_q;
            sec_logic_reset <= sec_reset_q;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sec_fast_b2b_en <= 1'b0;
        end else begin
            sec_fast_b2b_en <= 1'b0;
        end
    end

    assign short_sel[PRI_BUS] = pri_short_q;
    assign short_sel[SEC_BUS] = sec_short_q;

    // One discard timer per bus
    genvar g;
    generate
        for (g = 0; g < NUM_BUSES; g++) begin : g_tmr
            pbcu_tmr_e                tmr_q;
            logic [DISCARD_CNT_W-1:0] cnt_q;
            logic [DISCARD_CNT_W-1:0] last;
            logic                     rst_tmr;

            // Limit select is sampled live, so a change applies mid-count
            // per-bus limit
            assign last = short_sel[g] ? SHORT_LAST : LONG_LAST;
            // Secondary timer restarts with the secondary interface
            assign rst_tmr = (g == SEC_BUS) && sec_reset_q;
            assign discard_now[g] = (tmr_q == PBCU_TMR_RUN) &&
                                    !dt_repeat[g] && !rst_tmr &&
                                    (cnt_q >= last);

            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    tmr_q <= PBCU_TMR_IDLE;
                    cnt_q <= '0;
                end else if (rst_tmr) begin
                    tmr_q <= PBCU_TMR_IDLE;
                    cnt_q <= '0;
                end else begin
                    case (tmr_q)
                        PBCU_TMR_IDLE: begin
                            if (dt_head_arrive[g]) begin
                                tmr_q <= PBCU_TMR_RUN;
                                cnt_q <= '0;
                            end
                        end
                        PBCU_TMR_RUN: begin
                            if (dt_repeat[g] || discard_now[g]) begin
                                tmr_q <= PBCU_TMR_IDLE;
                                cnt_q <= '0;
                            end else begin
                                cnt_q <= cnt_q + 1'b1;
                            end
                        end
                        default: begin
                            tmr_q <= PBCU_TMR_IDLE;
                            cnt_q <= '0;
                        end
                    endcase
                end
            end

            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    dt_discard[g] <= 1'b0;
                end else begin
                    dt_discard[g] <= discard_now[g];
                end
            end
        end
    endgenerate

    // Active-high pulse; pin polarity is handled outside this block
    // timeout and master abort SERR
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            primary_system_error_out <= 1'b0;
        end else begin
            primary_system_error_out <= cmd_serr_en &&
                ((tmo_serr_en_q && (|discard_now)) ||
                 (ma_event && !ma_delayed && ma_mode_q));
        end
    end

endmodule

/* tb/pbcu_bridge_ctrl_props.sv */
// Checker for the bridge control upper half block
module pbcu_bridge_ctrl_props
    import pbcu_pkg::*;
(
    input wire logic                 core_clk,
    input wire logic                 rst_b,
    input wire logic                 cfg_wr,
    input wire logic [7:0]           cfg_addr,
    input wire logic [3:0]           cfg_be,
    input wire logic [31:0]          cfg_wdata,
    input wire logic [31:0]          cfg_rdata,
    input wire logic                 cfg_rvalid,
    input wire logic                 cmd_io_en,
    input wire logic                 cmd_mem_en,
    input wire logic                 cmd_serr_en,
    input wire logic                 pri_valid,
    input wire logic                 pri_is_mem,
    input wire logic [31:0]          pri_addr,
    input wire logic                 pri_claim,
    input wire logic                 sec_valid,
    input wire logic                 sec_is_mem,
    input wire logic [31:0]          sec_addr,
    input wire logic                 sec_vga_ignore,
    input wire logic                 ma_event,
    input wire logic                 ma_delayed,
    input wire logic                 ma_trdy_done,
    input wire logic                 ma_target_abort,
    input wire logic                 sec_rst_out_b,
    input wire logic                 sec_logic_reset,
    input wire logic                 sec_fast_b2b_en,
    input wire logic [NUM_BUSES-1:0] dt_discard,
    input wire logic                 primary_system_error_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic vga_q;
    logic ma_q;
    logic b22_q;
    logic wsel;
    logic en2;
    assign wsel = cfg_wr && cfg_addr == BRIDGE_CONTROL_UPPER_OFF;
    assign en2 = cmd_io_en && cmd_mem_en;
    // Shadow of the control fields that the properties depend on
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            vga_q <= 1'b0;
            ma_q <= 1'b0;
            b22_q <= 1'b0;
        end else if (wsel && cfg_be[BE_LANE2]) begin
            vga_q <= cfg_wdata[VGA_DECODE_BIT];
            ma_q <= cfg_wdata[MA_MODE_BIT];
            b22_q <= cfg_wdata[SEC_RESET_BIT];
        end
    end
    function automatic logic mhit(input logic [31:0] a);
        return a >= VGA_MEM_LO && a <= VGA_MEM_HI;
    endfunction
    property p_b2b;
        !sec_fast_b2b_en;
    endproperty
    property p_rst;
        sec_rst_out_b == !sec_logic_reset;
    endproperty
    property p_rst_dly;
        sec_logic_reset == $past(b22_q);
    endproperty
    property p_resv;
        cfg_rvalid |-> cfg_rdata[31:28] == 4'h0 && !cfg_rdata[20];
    endproperty
    property p_vga_mem;
        pri_valid && pri_is_mem && mhit(pri_addr) && vga_q && en2
            |=> pri_claim;
    endproperty
    property p_cmd;
        pri_valid && pri_is_mem && mhit(pri_addr) && !en2 |=> !pri_claim;
    endproperty
    property p_sec_ign;
        sec_valid && sec_is_mem && mhit(sec_addr) && vga_q && en2
            |=> sec_vga_ignore;
    endproperty
    property p_ma0;
        ma_event && ma_delayed && !ma_q |=> ma_trdy_done && !ma_target_abort;
    endproperty
    property p_ma1;
        ma_event && ma_delayed && ma_q |=> ma_target_abort && !ma_trdy_done;
    endproperty
    property p_ma_serr;
        ma_event && !ma_delayed && ma_q && cmd_serr_en
            |=> primary_system_error_out;
    endproperty
    a_b2b: assert property (p_b2b)
        else $error("fast back-to-back enable seen high");
    a_rst: assert property (p_rst)
        else $error("secondary reset outputs disagree");
    a_rst_dly: assert property (p_rst_dly)
        else $error("secondary reset does not follow its bit");
    a_resv: assert property (p_resv)
        else $error("reserved bits read nonzero");
    a_vga_mem: assert property (p_vga_mem)
        else $error("frame buffer cycle not claimed");
    a_cmd: assert property (p_cmd)
        else $error("claimed with command enables off");
    a_sec_ign: assert property (p_sec_ign)
        else $error("secondary frame buffer cycle not ignored");
    a_ma0: assert property (p_ma0)
        else $error("abort mode 0 not completed with ready");
    a_ma1: assert property (p_ma1)
        else $error("abort mode 1 not ended with target abort");
    a_ma_serr: assert property (p_ma_serr)
        else $error("posted abort gave no system error");
    c_claim: cover property (pri_claim);
    c_disc: cover property (dt_discard != 2'h0);
    c_tabort: cover property (ma_target_abort);
endmodule

bind pbcu_bridge_ctrl pbcu_bridge_ctrl_props u_props (.*);

/* tb/pbcu_initiator_model.sv */
// Initiator that repeats a retried request a set number of clocks later
module pbcu_initiator_model (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        arrive,
    input  wire logic [15:0] wait_clks,
    output logic             rep
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt_q;
    logic        run_q;
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            run_q <= 1'b0;
            cnt_q <= 16'h0;
        end else if (arrive) begin
            run_q <= 1'b1;
            cnt_q <= 16'h0;
        end else if (run_q) begin
            run_q <= cnt_q != wait_clks && cnt_q != 16'hFFFF;
            cnt_q <= cnt_q + 16'h1;
        end
    end
    // Launched off the falling edge so the bridge samples it cleanly
    always @(negedge core_clk) begin
        rep <= run_q && cnt_q == wait_clks;
    end
endmodule

/* tb/test_pbcu_bridge_ctrl.sv */
// Self-checking bench for the bridge control upper half block
module test_pbcu_bridge_ctrl
    import pbcu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LL = 40;
    localparam int SL = 10;
    localparam logic [7:0] OFF = BRIDGE_CONTROL_UPPER_OFF;
    localparam logic [31:0] MSK = 32'h0B68_0000;
    logic core_clk, rst_b, cfg_wr, cfg_rd, cfg_rvalid;
    logic cmd_io_en, cmd_mem_en, cmd_serr_en, isa_mode;
    logic pri_valid, pri_is_mem, pri_is_io, pri_claim;
    logic sec_valid, sec_is_mem, sec_is_io, sec_vga_ignore;
    logic ma_event, ma_delayed, ma_read, ma_trdy_done, ma_target_abort;
    logic sec_rst_out_b, sec_logic_reset, sec_fast_b2b_en;
    logic primary_system_error_out, pv, mv, st;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, io_base, io_limit, pri_addr;
    logic [31:0] sec_addr, ma_read_data, mrd, v;
    logic [1:0]  dt_head_arrive, dt_repeat, dt_discard;
    logic [15:0] wc [2];
    logic [31:0] rdq [$];
    logic [1:0]  dq [$];
    logic [34:0] mq [$];
    logic [34:0] tq [$];
    int          failures, n_checks, cyc;
    assign pri_is_io = !pri_is_mem;
    assign sec_is_mem = pri_is_mem;
    assign sec_is_io = !pri_is_mem;
    assign sec_addr = pri_addr;
    pbcu_bridge_ctrl #(.LONG_LIMIT(LL), .SHORT_LIMIT(SL)) DUT (.*);
    for (genvar b = 0; b < 2; b++) begin : g_ini
        pbcu_initiator_model u_ini (.core_clk(core_clk), .rst_b(rst_b),
            .arrive(dt_head_arrive[b]), .wait_clks(wc[b]),
            .rep(dt_repeat[b]));
    end
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task check(input string n, input logic [63:0] g, input logic [63:0] e);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s exp %0h got %0h", n, e, g);
        end
    endtask
    task report_and_stop;
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge core_clk);
        {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, be, d};
        @(negedge core_clk);
        cfg_wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(negedge core_clk);
        {cfg_rd, cfg_addr} = {1'b1, a};
        rdq.push_back(e);
        @(negedge core_clk);
        cfg_rd = 1'b0;
    endtask
    task dec(input logic m, input logic [31:0] a, input logic [1:0] e);
        @(negedge core_clk);
        {pri_valid, sec_valid, pri_is_mem, pri_addr} = {2'b11, m, a};
        dq.push_back(e);
        @(negedge core_clk);
        {pri_valid, sec_valid} = 2'b00;
    endtask
    task ma(input logic d, input logic r, input logic [2:0] e);
        @(negedge core_clk);
        {ma_event, ma_delayed, ma_read} = {1'b1, d, r};
        if (e[2] && r)
            mrd = MA_READ_ONES;
        mq.push_back({e, mrd});
        @(negedge core_clk);
        ma_event = 1'b0;
    endtask
    task tmo(input int b, input logic [31:0] c, input logic [15:0] d);
        int   l;
        logic h;
        l = c[24 + b] ? SL : LL;
        // Secondary timer is held idle under secondary reset
        h = b == 1 && c[22];
        wr(OFF, 4'hC, c);
        wc[b] = d;
        @(negedge core_clk);
        dt_head_arrive[b] = 1'b1;
        if (d >= l && !h) begin
            st = 1'b1;
            tq.push_back({2'(1 << b), c[27], cyc + l + 2});
        end
        @(negedge core_clk);
        dt_head_arrive[b] = 1'b0;
        repeat (l + 4) @(negedge core_clk);
        rd(OFF, (c & MSK) | {5'h0, st, 26'h0});
    endtask
    // Outputs are read at the rising edge, before that edge's updates land
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cfg_rvalid === 1'b1)
            check("rdata", cfg_rdata, rdq.pop_front());
        if (pv)
            check("claim", {pri_claim, sec_vga_ignore}, dq.pop_front());
        if (mv)
            check("abort", {ma_trdy_done, ma_target_abort,
                primary_system_error_out, ma_read_data}, mq.pop_front());
        if (dt_discard !== 2'b00)
            check("discard", {dt_discard, primary_system_error_out, cyc},
                tq.pop_front());
        pv = pri_valid;
        mv = ma_event;
        if (cyc == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(4));
        {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
        {cmd_io_en, cmd_mem_en, cmd_serr_en, isa_mode} = 4'h0;
        {pri_valid, sec_valid, pri_is_mem, pri_addr} = '0;
        {ma_event, ma_delayed, ma_read, dt_head_arrive} = '0;
        {pv, mv, st, mrd, failures, n_checks, cyc} = '0;
        wc[0] = 16'hFFFF;
        wc[1] = 16'hFFFF;
        io_base = 32'h0000_1000;
        io_limit = 32'h0000_1FFF;
        rst_b = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_b = 1'b1;
        rd(OFF, BRIDGE_CONTROL_UPPER_RST);
        for (int i = 0; i < 6; i++) begin
            v = $urandom;
            wr(OFF, 4'hC, v);
            rd(OFF, v & MSK);
            check("srst", sec_rst_out_b, !v[22]);
        end
        wr(8'h40, 4'hC, 32'hFFFF_FFFF);
        wr(OFF, 4'h3, 32'hFFFF_FFFF);
        rd(OFF, v & MSK);
        rd(8'h40, 32'h0);
        wr(OFF, 4'hC, 32'hFFFF_FFFF);
        rd(OFF, MSK);
        wr(OFF, 4'hC, 32'h0);
        {cmd_io_en, cmd_mem_en, cmd_serr_en} = 3'b111;
        dec(1'b1, 32'h000A_0000, 2'b00);
        dec(1'b0, 32'h0000_03C0, 2'b00);
        dec(1'b0, 32'h0000_1010, 2'b10);
        isa_mode = 1'b1;
        dec(1'b0, 32'h0000_1110, 2'b00);
        dec(1'b0, 32'h0000_1010, 2'b10);
        wr(OFF, 4'hC, 32'h0008_0000);
        dec(1'b1, 32'h000A_0000, 2'b11);
        dec(1'b1, 32'h000B_FFFF, 2'b11);
        dec(1'b1, 32'h000C_0000, 2'b00);
        dec(1'b1, 32'h0009_FFFF, 2'b00);
        dec(1'b0, 32'h0000_03B0, 2'b11);
        dec(1'b0, 32'h0000_03BB, 2'b11);
        dec(1'b0, 32'h0000_03BC, 2'b00);
        dec(1'b0, 32'h0000_FFDF, 2'b11);
        dec(1'b0, 32'h0001_03C0, 2'b00);
        cmd_mem_en = 1'b0;
        dec(1'b0, 32'h0000_03C0, 2'b00);
        dec(1'b1, 32'h000A_0000, 2'b00);
        cmd_mem_en = 1'b1;
        wr(OFF, 4'hC, 32'h0);
        ma(1'b1, 1'b1, 3'b100);
        ma(1'b1, 1'b0, 3'b100);
        ma(1'b0, 1'b0, 3'b000);
        wr(OFF, 4'hC, 32'h0020_0000);
        ma(1'b1, 1'b1, 3'b010);
        ma(1'b0, 1'b0, 3'b001);
        cmd_serr_en = 1'b0;
        ma(1'b0, 1'b0, 3'b000);
        cmd_serr_en = 1'b1;
        tmo(0, 32'h0900_0000, 16'hFFFF);
        tmo(0, 32'h0900_0000, 16'h3);
        tmo(0, 32'h0000_0000, 16'hFFFF);
        tmo(1, 32'h0A00_0000, 16'hFFFF);
        tmo(1, 32'h0800_0000, 16'h14);
        tmo(1, 32'h0840_0000, 16'hFFFF);
        wr(OFF, 4'hC, 32'h0400_0000);
        st = 1'b0;
        rd(OFF, 32'h0);
        repeat (3) @(negedge core_clk);
        check("queues", rdq.size() + dq.size() + mq.size() + tq.size(),
            0);
        report_and_stop();
    end
endmodule
